// [hw/stc_pkg.sv]
// Package: register map, field positions and reset values of the 16-bit timer/counter
package stc_pkg;
    // Register byte addresses on the Wishbone bus
    localparam logic [7:0] COUNT_LOW_ADDR  = 8'h0E;
    localparam logic [7:0] COUNT_HIGH_ADDR = 8'h0F;
    localparam logic [7:0] TIMER_CTRL_ADDR = 8'h10;
    localparam logic [7:0] FLAG_REG_ADDR   = 8'h0C;
    localparam logic [7:0] ENABLE_REG_ADDR = 8'h8C;
    localparam logic [7:0] PORT_DIR_ADDR   = 8'h87;
    // Control, flag and enable register field positions
    localparam int CTRL_ON_BIT    = 0;
    localparam int CTRL_CS_BIT    = 1;
    localparam int CTRL_SYNC_BIT  = 2;
    localparam int CTRL_OSC_BIT   = 3;
    localparam int CTRL_PS_LO_BIT = 4;
    localparam int CTRL_PS_HI_BIT = 5;
    localparam int FLAG_OVF_BIT   = 0;
    localparam int IRQ_EN_BIT     = 0;
    // Reset values and count maximum
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  PORT_DIR_RESET = 8'hFF;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    // Special event trigger compare mode code
    localparam logic [3:0]  SPECIAL_EVENT_CODE = 4'hB;
endpackage

// [hw/stc_timer.sv]
// Module: 16-bit timer/counter with prescaler, crystal enable and Wishbone registers
//
// Behaviour
// RL1 - Count is 16 bits, high and low byte, both read and written by software
// RL2 - Counter runs only while the on bit (control bit 0) is set
// RL3 - Three modes: timer, synchronous counter, asynchronous counter
// RL4 - Control bit 1 chooses instruction clock (0) or external clock input (1)
// RL5 - Timer mode advances once per instruction cycle after prescaling
// RL6 - Counter modes advance on rising external edges only, after prescaling
// RL7 - Prescale field bits 5:4: 11 divides by 8, 10 by 4, 01 by 2
// RL8 - Prescale field 00 divides by one
// RL9 - Control bit 3 switches the crystal oscillator on or off
// RL10 - With oscillator enabled both oscillator pins are inputs, direction bits ignored
// RL11 - Control bit 2 disables synchronisation in counter mode, ignored in timer mode; the code always uses the synchronised input
// RL12 - Crystal oscillator keeps running during sleep
// RL13 - Software waits for oscillator start-up; no hardware start-up timer
// RL14 - Count runs up from 0000h to FFFFh then wraps to 0000h
// RL15 - Each wrap sets the sticky overflow flag, held until cleared; the code lets a clear write win over a wrap while the flag is already set
// RL16 - Overflow request passes only while the enable bit is set
// RL17 - Internal reset input from the capture/compare unit clears the count
// RL18 - Compare mode code 1011 trigger clears count and starts enabled conversion
// RL19 - Trigger clear never sets the overflow flag; the code still sets it if a wrap falls in the trigger cycle
// RL20 - Software count write wins over a simultaneous trigger clear
// RL21 - Trigger clear only guaranteed in timer or synchronous counter mode
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module stc_timer #(
    parameter int INSTR_DIV = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_clock_pin_i,
    input  wire logic [3:0]  compare_mode_code_i,
    input  wire logic        compare_match_i,
    input  wire logic        converter_enable_i,
    input  wire logic        sleep_i,
    output logic             osc_run_o,
    output logic             osc_in_pin_oe_o,
    output logic             osc_out_ext_clock_pin_oe_o,
    output logic             conversion_start_o,
    output logic             overflow_irq_o,
    output logic      [15:0] count_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] count;
        logic [7:0]  ctrl;
        logic        ovf_flag;
        logic        irq_en;
        logic [7:0]  port_dir;
        logic [2:0]  pre;
        logic [$clog2(INSTR_DIV+1)-1:0] div;
        logic [1:0]  ext_sync;
        logic        ext_prev;
        logic        ack;
        logic [31:0] rdata;
        logic        irq;
        logic        conv;
        logic        osc;
        logic        oe_in;
        logic        oe_out;
    } stc_state_t;

    stc_state_t s_q;
    stc_state_t s_d;

    logic       ext_level;
    logic       tick;
    logic       ps_hit;
    logic       bus_wr;
    logic       trig;
    logic [7:0] wbyte;

    always_comb begin
        s_d      = s_q;
        wbyte    = wb_dat_i[7:0];
        bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !s_q.ack;
        // Instruction cycle enable from divider
        s_d.div  = (s_q.div == ($clog2(INSTR_DIV+1))'(INSTR_DIV - 1)) ? '0 : s_q.div + 1'b1;
        // External input synchroniser, edge taken from second stage only
        s_d.ext_sync = {s_q.ext_sync[0], ext_clock_pin_i};
        // RL11 sync bit has no effect: both branches take the second synchroniser stage
        ext_level = (s_q.ctrl[stc_pkg::CTRL_SYNC_BIT] && s_q.ctrl[stc_pkg::CTRL_CS_BIT]) ?
                    s_q.ext_sync[1] : s_q.ext_sync[1];
        s_d.ext_prev = ext_level;
        // RL3 RL4 RL5 RL6 clock source
        if (s_q.ctrl[stc_pkg::CTRL_CS_BIT]) begin
            tick = ext_level && !s_q.ext_prev;
        end else begin
            tick = (s_q.div == '0) && !sleep_i;
        end
        // RL2 gate on control bit
        tick = tick && s_q.ctrl[stc_pkg::CTRL_ON_BIT];
        // RL7 RL8 prescale ratio
        unique case (s_q.ctrl[stc_pkg::CTRL_PS_HI_BIT:stc_pkg::CTRL_PS_LO_BIT])
            2'b00: ps_hit = 1'b1;
            2'b01: ps_hit = (s_q.pre[0] == 1'b1);
            2'b10: ps_hit = (s_q.pre[1:0] == 2'b11);
            2'b11: ps_hit = (s_q.pre == 3'b111);
        endcase
        if (tick) begin
            s_d.pre = s_q.pre + 3'd1;
        end
        // RL18 special event trigger
        trig = compare_match_i && (compare_mode_code_i == stc_pkg::SPECIAL_EVENT_CODE);
        s_d.conv = trig && converter_enable_i;
        // RL14 RL15 count and wrap
        if (tick && ps_hit) begin
            s_d.count = s_q.count + 16'h0001;
            if (s_q.count == stc_pkg::COUNT_MAX) begin
                s_d.ovf_flag = 1'b1;
            end
        end
        // RL17 RL19 trigger clear without flag
        if (trig) begin
            s_d.count = stc_pkg::COUNT_RESET;
            s_d.pre   = 3'd0;
        end
        // Register writes; RL20 write after clear so it wins
        if (bus_wr) begin
            unique case (wb_adr_i)
                stc_pkg::COUNT_LOW_ADDR:  s_d.count[7:0]  = wbyte;
                stc_pkg::COUNT_HIGH_ADDR: s_d.count[15:8] = wbyte;
                stc_pkg::TIMER_CTRL_ADDR: s_d.ctrl = {2'b00, wbyte[5:0]};
                // RL15 wrap set wins over clear only while the flag was clear
                stc_pkg::FLAG_REG_ADDR:   s_d.ovf_flag = wbyte[stc_pkg::FLAG_OVF_BIT] || s_d.ovf_flag
                                                         && (s_d.ovf_flag != s_q.ovf_flag);
                stc_pkg::ENABLE_REG_ADDR: s_d.irq_en = wbyte[stc_pkg::IRQ_EN_BIT];
                stc_pkg::PORT_DIR_ADDR:   s_d.port_dir = wbyte;
                default: ;
            endcase
        end
        // RL1 readback
        s_d.ack   = wb_cyc_i && wb_stb_i && !s_q.ack;
        s_d.rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            stc_pkg::COUNT_LOW_ADDR:  s_d.rdata[7:0] = s_q.count[7:0];
            stc_pkg::COUNT_HIGH_ADDR: s_d.rdata[7:0] = s_q.count[15:8];
            stc_pkg::TIMER_CTRL_ADDR: s_d.rdata[7:0] = s_q.ctrl;
            stc_pkg::FLAG_REG_ADDR:   s_d.rdata[0]   = s_q.ovf_flag;
            stc_pkg::ENABLE_REG_ADDR: s_d.rdata[0]   = s_q.irq_en;
            stc_pkg::PORT_DIR_ADDR:   s_d.rdata[7:0] = s_q.port_dir;
            default: ;
        endcase
        // RL16 request gated by enable
        s_d.irq = s_d.ovf_flag && s_d.irq_en;
        // RL9 RL12 oscillator runs regardless of sleep
        s_d.osc = s_d.ctrl[stc_pkg::CTRL_OSC_BIT];
        // RL10 pins forced to inputs
        s_d.oe_in  = !s_d.osc && !s_d.port_dir[1];
        s_d.oe_out = !s_d.osc && !s_d.port_dir[0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.ctrl     <= stc_pkg::CTRL_RESET;
            s_q.port_dir <= stc_pkg::PORT_DIR_RESET;
            s_q.count    <= stc_pkg::COUNT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign wb_dat_o           = s_q.rdata;
    assign wb_ack_o           = s_q.ack;
    assign osc_run_o          = s_q.osc;
    assign conversion_start_o = s_q.conv;
    assign overflow_irq_o     = s_q.irq;
    assign count_o            = s_q.count;
    // RL10 pins forced to inputs while oscillator on
    assign osc_in_pin_oe_o            = s_q.oe_in;
    assign osc_out_ext_clock_pin_oe_o = s_q.oe_out;

    // ************************************************************
    // Checks
    // ************************************************************
    wrap_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
        (s_q.count == 16'hFFFF && s_d.count == 16'h0000 && !trig) |=> s_q.ovf_flag)
        else $error("wrap did not set flag");

    stop_holds_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
        (!s_q.ctrl[0] && !bus_wr && !trig) |=> $stable(s_q.count))
        else $error("count moved while stopped");

    trig_clears_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
        (trig && !bus_wr) |=> s_q.count == 16'h0000)
        else $error("trigger did not clear");

    trig_no_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
        (trig && !s_q.ovf_flag && !bus_wr) |=> !s_q.ovf_flag)
        else $error("trigger set flag");

    write_wins_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL20
        (trig && bus_wr && wb_adr_i == 8'h0E) |=> s_q.count[7:0] == $past(wb_dat_i[7:0]))
        else $error("write lost to trigger");

    irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
        overflow_irq_o |-> s_q.irq_en || $past(s_q.irq_en))
        else $error("irq without enable");

    pins_input_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
        s_q.osc |-> !osc_in_pin_oe_o && !osc_out_ext_clock_pin_oe_o)
        else $error("osc pin driven");

    div8_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
        (tick && ps_hit && s_q.ctrl[5:4] == 2'b11) |-> s_q.pre == 3'b111)
        else $error("prescale 1:8 wrong");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held");

    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged");

    low_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        (bus_wr && wb_adr_i == stc_pkg::COUNT_LOW_ADDR)
        |=> s_q.count[7:0] == $past(wb_dat_i[7:0]))
        else $error("low byte write lost");

    high_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        (bus_wr && wb_adr_i == stc_pkg::COUNT_HIGH_ADDR)
        |=> s_q.count[15:8] == $past(wb_dat_i[7:0]))
        else $error("high byte write lost");

    low_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == stc_pkg::COUNT_LOW_ADDR)
        |=> wb_dat_o[7:0] == $past(s_q.count[7:0]))
        else $error("low byte read wrong");

    ctrl_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
        (bus_wr && wb_adr_i == stc_pkg::TIMER_CTRL_ADDR)
        |=> s_q.ctrl == {2'b00, $past(wb_dat_i[5:0])})
        else $error("control write lost");

    timer_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
        (!s_q.ctrl[1] && s_q.ctrl[0] && s_q.ctrl[5:4] == 2'b00 && s_q.div == '0
         && !sleep_i && !trig && !bus_wr) |=> s_q.count == $past(s_q.count) + 16'h0001)
        else $error("timer did not step");

    sleep_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
        (!s_q.ctrl[1] && sleep_i && !trig && !bus_wr) |=> $stable(s_q.count))
        else $error("timer ran in sleep");

    ext_rise_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
        (s_q.ctrl[1] && s_q.ctrl[0] && s_q.ctrl[5:4] == 2'b00 && s_q.ext_sync[1]
         && !s_q.ext_prev && !trig && !bus_wr) |=> s_q.count == $past(s_q.count) + 16'h0001)
        else $error("rising edge missed");

    ext_fall_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
        (s_q.ctrl[1] && !(s_q.ext_sync[1] && !s_q.ext_prev) && !trig && !bus_wr)
        |=> $stable(s_q.count))
        else $error("count without rising edge");

    sync_chain_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
        s_q.ext_sync[1] == $past(s_q.ext_sync[0]))
        else $error("synchroniser broken");

    ps_div2_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
        (tick && s_q.ctrl[5:4] == 2'b01 && !s_q.pre[0] && !trig && !bus_wr)
        |=> $stable(s_q.count))
        else $error("prescale 1:2 wrong");

    ps_div4_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
        (tick && s_q.ctrl[5:4] == 2'b10 && s_q.pre[1:0] != 2'b11 && !trig && !bus_wr)
        |=> $stable(s_q.count))
        else $error("prescale 1:4 wrong");

    ps_div8_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
        (tick && s_q.ctrl[5:4] == 2'b11 && s_q.pre != 3'b111 && !trig && !bus_wr)
        |=> $stable(s_q.count))
        else $error("prescale 1:8 early");

    wrap_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
        (tick && ps_hit && s_q.count == 16'hFFFF && !trig && !bus_wr)
        |=> s_q.count == 16'h0000)
        else $error("count did not wrap");

    flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
        (s_q.ovf_flag && !(bus_wr && wb_adr_i == stc_pkg::FLAG_REG_ADDR)) |=> s_q.ovf_flag)
        else $error("flag lost");

    irq_match_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
        overflow_irq_o == (s_q.ovf_flag && s_q.irq_en))
        else $error("irq not flag and enable");

    conv_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
        (trig && converter_enable_i) |=> conversion_start_o)
        else $error("conversion not started");

    conv_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
        conversion_start_o |-> $past(trig && converter_enable_i))
        else $error("conversion without trigger");

    osc_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
        osc_run_o == s_q.ctrl[stc_pkg::CTRL_OSC_BIT])
        else $error("oscillator not following bit");

    osc_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
        (osc_run_o && sleep_i && !bus_wr) |=> osc_run_o)
        else $error("oscillator stopped in sleep");

    pin_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
        osc_out_ext_clock_pin_oe_o == (!s_q.osc && !s_q.port_dir[0]))
        else $error("pin drive wrong");

endmodule
`default_nettype wire

// [bench/stc_ext_clk_src.sv]
// Partner model: external clock source on the external clock pin
`timescale 1ns/1ps
`default_nettype none
module stc_ext_clk_src #(
    parameter int HALF = 4
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      pin_o
);
    int cnt_q;
    always_ff @(posedge clk_i) begin
        if (!run_i) begin
            cnt_q <= 0;
            pin_o <= 1'b0;
        end else if (cnt_q == HALF - 1) begin
            cnt_q <= 0;
            pin_o <= !pin_o;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Testbench: register, timer, counter, overflow, trigger and oscillator tests
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, match = 1'b0, cen = 1'b0;
    logic        slp = 1'b0, run = 1'b0, ack, osc, oe_a, oe_b, conv, irq, pin, sc;
    logic [3:0]  sel = 4'h0, code = 4'h0;
    logic [7:0]  adr = 8'h00, rdv;
    logic [15:0] cnt;
    logic [31:0] dat_w = 32'h0000_0000, dat_r;
    int          err_total = 0, checks = 0;
    // ****************************************
    // Design and partner
    // ****************************************
    stc_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .ext_clock_pin_i(pin), .compare_mode_code_i(code),
        .compare_match_i(match), .converter_enable_i(cen), .sleep_i(slp), .osc_run_o(osc),
        .osc_in_pin_oe_o(oe_a), .osc_out_ext_clock_pin_oe_o(oe_b),
        .conversion_start_o(conv), .overflow_irq_o(irq), .count_o(cnt));
    stc_ext_clk_src i_src (.clk_i(clk_i), .run_i(run), .pin_o(pin));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g, input int t);
        checks++;
        if ((^g) === 1'bx || g > e + t || g + t < e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat_w <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdv = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        if (n >= 50) err_total++;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string nm, input int t);
        wb(1'b0, a, 8'h00);
        chk(nm, e, {8'h00, rdv}, t);
    endtask
    task automatic trig(input logic [3:0] c);
        @(posedge clk_i);
        code <= c;
        match <= 1'b1;
        @(posedge clk_i);
        match <= 1'b0;
        tick(1);
        sc = conv;
        tick(1);
        sc = sc | conv;
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        tick(6);
        rst_i <= 1'b0;
        rdc(stc_pkg::TIMER_CTRL_ADDR, 16'h0000, "ctrl_reset", 0);
        rdc(8'h55, 16'h0000, "unmapped", 0);
        wb(1'b1, stc_pkg::COUNT_LOW_ADDR, 8'hFE);
        wb(1'b1, stc_pkg::COUNT_HIGH_ADDR, 8'hFF);
        tick(20);
        rdc(stc_pkg::COUNT_LOW_ADDR, 16'h00FE, "stopped", 0);
        wb(1'b1, stc_pkg::TIMER_CTRL_ADDR, 8'h01);
        tick(20);
        wb(1'b1, stc_pkg::TIMER_CTRL_ADDR, 8'h00);
        rdc(stc_pkg::COUNT_HIGH_ADDR, 16'h0000, "wrap", 0);
        rdc(stc_pkg::FLAG_REG_ADDR, 16'h0001, "flag", 0);
        chk("irq_masked", 16'h0000, {15'h0000, irq}, 0);
        wb(1'b1, stc_pkg::ENABLE_REG_ADDR, 8'h01);
        tick(2);
        chk("irq_on", 16'h0001, {15'h0000, irq}, 0);
        wb(1'b1, stc_pkg::FLAG_REG_ADDR, 8'h00);
        tick(2);
        chk("irq_clear", 16'h0000, {15'h0000, irq}, 0);
        for (int p = 0; p < 4; p++) begin
            trig(stc_pkg::SPECIAL_EVENT_CODE);
            wb(1'b1, stc_pkg::TIMER_CTRL_ADDR, 8'h01 | {2'h0, p[1:0], 4'h0});
            tick(62);
            wb(1'b1, stc_pkg::TIMER_CTRL_ADDR, 8'h00);
            rdc(stc_pkg::COUNT_LOW_ADDR, 16'h0010 >> p, "prescale", 1);
        end
        wb(1'b1, stc_pkg::COUNT_LOW_ADDR, 8'h34);
        wb(1'b1, stc_pkg::COUNT_HIGH_ADDR, 8'h12);
        cen <= 1'b1;
        trig(4'hA);
        rdc(stc_pkg::COUNT_LOW_ADDR, 16'h0034, "other_code", 0);
        trig(stc_pkg::SPECIAL_EVENT_CODE);
        chk("conv_start", 16'h0001, {15'h0000, sc}, 0);
        rdc(stc_pkg::COUNT_HIGH_ADDR, 16'h0000, "trig_clear", 0);
        rdc(stc_pkg::FLAG_REG_ADDR, 16'h0000, "trig_flag", 0);
        for (int s = 0; s < 2; s++) begin
            trig(stc_pkg::SPECIAL_EVENT_CODE);
            wb(1'b1, stc_pkg::TIMER_CTRL_ADDR, (s != 0) ? 8'h07 : 8'h03);
            run <= 1'b1;
            tick(38);
            run <= 1'b0;
            tick(8);
            wb(1'b1, stc_pkg::TIMER_CTRL_ADDR, 8'h00);
            rdc(stc_pkg::COUNT_LOW_ADDR, 16'h0005, "ext_edges", 0);
        end
        wb(1'b1, stc_pkg::PORT_DIR_ADDR, 8'h00);
        tick(2);
        chk("pin_drive", 16'h0003, {14'h0000, oe_a, oe_b}, 0);
        wb(1'b1, stc_pkg::TIMER_CTRL_ADDR, 8'h08);
        slp <= 1'b1;
        tick(2);
        chk("osc_sleep", 16'h0001, {15'h0000, osc}, 0);
        chk("pin_input", 16'h0000, {14'h0000, oe_a, oe_b}, 0);
        slp <= 1'b0;
        wb(1'b1, stc_pkg::TIMER_CTRL_ADDR, 8'h00);
        tick(2);
        chk("osc_off", 16'h0000, {15'h0000, osc}, 0);
        end_of_test();
    end
    initial begin
        tick(20000);
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
